// ===== bench/uncore_conflict_memq_event_select_tb.sv
`timescale 1ns/1ps
`default_nettype none

module uncore_conflict_memq_event_select_tb;
  import event_select_pkg::*;

  logic refClk;
  logic reset;
  event_sel_t sel;
  conflict_dealloc_t dealloc;
  logic [2:0] trk [3];
  bypass_req_t bypassReq;
  logic [2:0] isocRdFull, isocWrFull, rdOut, wrOut, m;
  logic [5:0] nOcc [3];
  logic [5:0] iOcc [3];
  logic issueCh0;
  logic [31:0] eventCount;
  logic selValid;
  logic limitErr;
  int failures;
  int testsRun;
  int nv [3] = '{3, 5, 9};
  int iv [3] = '{17, 34, 63};

  uncore_conflict_memq_event_select #(.OCC_W(6), .COUNT_W(32)) dut_u (
    .ref_clk(refClk), .reset(reset), .sel(sel), .conflictDealloc(dealloc),
    .trackerConflicts(trk), .bypassReq(bypassReq), .isocReadFull(isocRdFull),
    .isocWriteFull(isocWrFull), .readOutstanding(rdOut), .writeOutstanding(wrOut),
    .normalReadOcc(nOcc), .isocReadOcc(iOcc), .normalReadIssueCh0(issueCh0),
    .eventCount(eventCount), .selValid(selValid), .conflictLimitError(limitErr));

  initial
  begin
    refClk = 1'b0;
    forever #5 refClk = ~refClk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] expd);
    testsRun++;
    if (got !== expd)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, expd);
    end
  endtask

  task automatic idle();
    dealloc = '0;
    bypassReq = '0;
    {isocRdFull, isocWrFull, rdOut, wrOut} = 12'h0;
    trk = '{default: 3'h0};
    nOcc = '{default: 6'h0};
    iOcc = '{default: 6'h0};
    issueCh0 = 1'b0;
  endtask

  task automatic give_verdict();
    if (failures == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Inputs stay up for n edges; then one idle edge so the next caller
  // drives in a fresh time step
  task automatic run(input logic [7:0] ev, input logic [7:0] um, input int n,
                     input logic [31:0] expd, input logic v);
    logic [31:0] base;
    sel = '{eventNum: ev, unitMask: um};
    base = eventCount;
    repeat (n) @(posedge refClk);
    #1;
    chk(eventCount - base, expd);
    chk({31'h0, selValid}, {31'h0, v});
    idle();
    @(posedge refClk);
    #1;
  endtask

  initial
  begin
    failures = 0;
    testsRun = 0;
    reset = 1'b1;
    sel = '0;
    idle();
    repeat (16) @(posedge refClk);
    #1 reset = 1'b0;
    chk(eventCount, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        m = 3'(1 << c);
        rdOut = k ? ~m : m;
        wrOut = k ? m : ~m;
        run(EVT_BUSY, 8'(8'h01 << (c + 3 * k)), 3, 3, 1'b1);
        isocRdFull = k ? ~m : m;
        isocWrFull = k ? m : ~m;
        run(EVT_ISOC_FULL, 8'(8'h01 << (c + 3 * k)), 2, 2, 1'b1);
      end
      // Pairs first on the others only with the selected tracker below the bar, then on the selected tracker only
      trk = '{default: 3'h3};
      trk[c] = 3'h1;
      run(EVT_CONFLICT_CYCLES, 8'(8'h01 << c), 2, 0, 1'b1);
      trk = '{default: 3'h1};
      trk[c] = 3'h2;
      run(EVT_CONFLICT_CYCLES, 8'(8'h01 << c), 3, 3, 1'b1);
    end
    for (int c = 0; c < 4; c++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        nOcc[j] = 6'(nv[j]);
        iOcc[j] = 6'(iv[j]);
      end
      run(EVT_NORMAL_OCC, c == 3 ? UM_07 : 8'(8'h01 << c), 2,
          32'(2 * (c == 3 ? 17 : nv[c])), 1'b1);
      for (int j = 0; j < 3; j++)
        iOcc[j] = 6'(iv[j]);
      nOcc = '{default: 6'h3f};
      run(EVT_ISOC_OCC, c == 3 ? UM_07 : 8'(8'h01 << c), 2,
          32'(2 * (c == 3 ? 114 : iv[c])), 1'b1);
    end
    dealloc = '{dealloc: 1'b1, conflicts: 2'h2};
    run(EVT_CONFLICTS, UM_02, 3, 3, 1'b1);
    dealloc = '{dealloc: 1'b0, conflicts: 2'h2};
    run(EVT_CONFLICTS, UM_02, 3, 0, 1'b1);
    dealloc = '{dealloc: 1'b1, conflicts: 2'h3};
    run(EVT_CONFLICTS, UM_02, 2, 0, 1'b1);
    dealloc = '{dealloc: 1'b1, conflicts: 2'h3};
    run(EVT_CONFLICTS, UM_04, 2, 2, 1'b1);
    dealloc = '{dealloc: 1'b1, conflicts: 2'h2};
    run(EVT_CONFLICTS, UM_04, 2, 0, 1'b1);
    // Remote writes must not reach the bypass count
    for (int i = 0; i < 4; i++)
    begin
      bypassReq = '{valid: 1'b1, isLocal: i[1], isRead: i[0]};
      run(EVT_BYPASS, UM_01, 2, (i != 0) ? 2 : 0, 1'b1);
    end
    issueCh0 = 1'b1;
    run(EVT_NORMAL_READS, UM_01, 4, 4, 1'b1);
    issueCh0 = 1'b1;
    rdOut = 3'h7;
    run(EVT_NORMAL_READS, UM_02, 3, 0, 1'b0);
    chk({31'h0, limitErr}, 32'h0);
    trk = '{3'h4, 3'h0, 3'h0};
    run(EVT_CONFLICT_CYCLES, UM_01, 1, 1, 1'b1);
    chk({31'h0, limitErr}, 32'h1);
    reset = 1'b1;
    @(posedge refClk);
    #1 reset = 1'b0;
    chk(eventCount, 32'h0);
    chk({30'h0, limitErr, selValid}, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire

// ===== hdl/event_select_pkg.sv
package event_select_pkg;

  // Event numbers
  localparam logic [7:0] EVT_CONFLICTS = 8'h24;
  localparam logic [7:0] EVT_CONFLICT_CYCLES = 8'h25;
  localparam logic [7:0] EVT_BYPASS = 8'h26;
  localparam logic [7:0] EVT_ISOC_FULL = 8'h28;
  localparam logic [7:0] EVT_BUSY = 8'h29;
  localparam logic [7:0] EVT_NORMAL_OCC = 8'h2a;
  localparam logic [7:0] EVT_ISOC_OCC = 8'h2b;
  localparam logic [7:0] EVT_NORMAL_READS = 8'h2c;

  // Unit masks
  localparam logic [7:0] UM_01 = 8'h01;
  localparam logic [7:0] UM_02 = 8'h02;
  localparam logic [7:0] UM_04 = 8'h04;
  localparam logic [7:0] UM_07 = 8'h07;
  localparam logic [7:0] UM_08 = 8'h08;
  localparam logic [7:0] UM_10 = 8'h10;
  localparam logic [7:0] UM_20 = 8'h20;

  // Tracker indices in the per-tracker vectors
  localparam int TRK_HUB = 0;
  localparam int TRK_REMOTE = 1;
  localparam int TRK_LOCAL = 2;

  // Largest conflict set a tracker can hold
  localparam logic [1:0] MAX_CONFLICTS = 2'h3;
  localparam logic [1:0] MIN_CONFLICT = 2'h2;

  localparam logic [31:0] COUNT_RESET = 32'h0;

  typedef struct packed {
    logic [7:0] eventNum;
    logic [7:0] unitMask;
  } event_sel_t;

  // Conflict-table deallocation report
  typedef struct packed {
    logic dealloc;
    logic [1:0] conflicts;
  } conflict_dealloc_t;

  // Home-logic bypass request to the memory controller
  typedef struct packed {
    logic valid;
    logic isLocal;
    logic isRead;
  } bypass_req_t;

endpackage

// ===== hdl/uncore_conflict_memq_event_select.sv
// What this block does
// - 24H counts entries with two or three conflicts
// - Conflict entry counted only on deallocation
// - 25H counts cycles tracker holds conflicting pair
// - At most three requests conflict per address
// - 26H counts requests bypassing the home logic
// - Locals bypass freely; remote only reads bypass
// - 28H counts isochronous high-priority queue full cycles
// - 29H read-outstanding cycles per channel
// - 29H write-outstanding cycles per channel
// - 2AH normal read occupancy per channel
// - 2AH mask 07H sums normal occupancy
// - 2BH isochronous read occupancy per channel, all
// - 2CH mask 01H counts channel 0 normal reads
// - Cycle events advance once per active cycle
`timescale 1ns/1ps
`default_nettype none

module uncore_conflict_memq_event_select #(
  parameter int OCC_W = 6,
  parameter int COUNT_W = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Event selection
  input wire event_select_pkg::event_sel_t sel,
  // Home logic
  input wire event_select_pkg::conflict_dealloc_t conflictDealloc,
  input wire logic [2:0] trackerConflicts [3],
  input wire event_select_pkg::bypass_req_t bypassReq,
  // Memory controller, per channel except the channel 0 normal read issue
  input wire logic [2:0] isocReadFull,
  input wire logic [2:0] isocWriteFull,
  input wire logic [2:0] readOutstanding,
  input wire logic [2:0] writeOutstanding,
  input wire logic [OCC_W-1:0] normalReadOcc [3],
  input wire logic [OCC_W-1:0] isocReadOcc [3],
  input wire logic normalReadIssueCh0,
  // Result
  output logic [COUNT_W-1:0] eventCount,
  output logic selValid,
  output logic conflictLimitError
);
  import event_select_pkg::*;

  // Refuse widths the adder cannot serve
  if (OCC_W < 1 || OCC_W > 16 || COUNT_W < OCC_W + 2 || COUNT_W > 64)
  begin : gen_bad_width
    $error("Unsupported width parameters");
  end

  logic [OCC_W+1:0] increment;
  logic known;
  logic [COUNT_W-1:0] next_eventCount;
  logic next_selValid;
  logic next_conflictLimitError;
  logic [OCC_W+1:0] occSum;

  always_comb
  begin
    increment = '0;
    known = 1'b0;
    occSum = '0;
    unique case (sel.eventNum)
      EVT_CONFLICTS:
      begin
        if (sel.unitMask == UM_02)
        begin
          known = 1'b1;
          increment = (OCC_W+2)'(conflictDealloc.dealloc
                                 && conflictDealloc.conflicts == MIN_CONFLICT);
        end
        else if (sel.unitMask == UM_04)
        begin
          known = 1'b1;
          increment = (OCC_W+2)'(conflictDealloc.dealloc
                                 && conflictDealloc.conflicts == MAX_CONFLICTS);
        end
      end
      EVT_CONFLICT_CYCLES:
      begin
        if (sel.unitMask == UM_01)
        begin
          known = 1'b1;
          increment = (OCC_W+2)'(trackerConflicts[TRK_HUB] >= 3'(MIN_CONFLICT));
        end
        else if (sel.unitMask == UM_02)
        begin
          known = 1'b1;
          increment = (OCC_W+2)'(trackerConflicts[TRK_REMOTE] >= 3'(MIN_CONFLICT));
        end
        else if (sel.unitMask == UM_04)
        begin
          known = 1'b1;
          increment = (OCC_W+2)'(trackerConflicts[TRK_LOCAL] >= 3'(MIN_CONFLICT));
        end
      end
      EVT_BYPASS:
      begin
        // Remote writes never count as bypass
        if (sel.unitMask == UM_01)
        begin
          known = 1'b1;
          increment = (OCC_W+2)'(bypassReq.valid
                                 && (bypassReq.isLocal || bypassReq.isRead));
        end
      end
      EVT_ISOC_FULL:
      begin
        for (int c = 0; c < 3; c++)
        begin
          if (sel.unitMask == (UM_01 << c))
          begin
            known = 1'b1;
            increment = (OCC_W+2)'(isocReadFull[c]);
          end
          if (sel.unitMask == (UM_08 << c))
          begin
            known = 1'b1;
            increment = (OCC_W+2)'(isocWriteFull[c]);
          end
        end
      end
      EVT_BUSY:
      begin
        for (int c = 0; c < 3; c++)
        begin
          if (sel.unitMask == (UM_01 << c))
          begin
            known = 1'b1;
            increment = (OCC_W+2)'(readOutstanding[c]);
          end
          if (sel.unitMask == (UM_08 << c))
          begin
            known = 1'b1;
            increment = (OCC_W+2)'(writeOutstanding[c]);
          end
        end
      end
      EVT_NORMAL_OCC, EVT_ISOC_OCC:
      begin
        for (int c = 0; c < 3; c++)
        begin
          if (sel.unitMask[c])
          begin
            occSum = occSum + (OCC_W+2)'(sel.eventNum == EVT_NORMAL_OCC
                                         ? normalReadOcc[c] : isocReadOcc[c]);
          end
          if (sel.unitMask == (UM_01 << c))
          begin
            known = 1'b1;
          end
        end
        if (sel.unitMask == UM_07)
        begin
          known = 1'b1;
        end
        increment = known ? occSum : '0;
      end
      EVT_NORMAL_READS:
      begin
        if (sel.unitMask == UM_01)
        begin
          known = 1'b1;
          increment = (OCC_W+2)'(normalReadIssueCh0);
        end
      end
      default:
      begin
        known = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    next_selValid = known;
    next_eventCount = eventCount + COUNT_W'(increment);
    // Flag a conflict set beyond three
    next_conflictLimitError = conflictLimitError
      || (trackerConflicts[TRK_HUB] > 3'(MAX_CONFLICTS))
      || (trackerConflicts[TRK_REMOTE] > 3'(MAX_CONFLICTS))
      || (trackerConflicts[TRK_LOCAL] > 3'(MAX_CONFLICTS));
    if (reset)
    begin
      next_eventCount = COUNT_W'(COUNT_RESET);
      next_selValid = 1'b0;
      next_conflictLimitError = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    eventCount <= next_eventCount;
    selValid <= next_selValid;
    conflictLimitError <= next_conflictLimitError;
  end

  // Assertions
  conflict_dealloc_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_CONFLICTS && !conflictDealloc.dealloc)
    |=> eventCount == $past(eventCount))
    else $error("Conflict count moved without deallocation");

  conflict_two_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_CONFLICTS && sel.unitMask == UM_02 && conflictDealloc.dealloc
     && conflictDealloc.conflicts == MIN_CONFLICT)
    |=> eventCount == $past(eventCount) + COUNT_W'(1))
    else $error("Two-way conflict not counted");

  hub_cycles_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_CONFLICT_CYCLES && sel.unitMask == UM_01)
    |=> eventCount == $past(eventCount)
        + COUNT_W'($past(trackerConflicts[TRK_HUB]) >= 3'h2))
    else $error("Hub conflict cycle count wrong");

  bypass_remote_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_BYPASS && !bypassReq.isLocal && !bypassReq.isRead)
    |=> eventCount == $past(eventCount))
    else $error("Remote write counted as bypass");

  isoc_full_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_ISOC_FULL && sel.unitMask == UM_10 && isocWriteFull[1])
    |=> eventCount == $past(eventCount) + COUNT_W'(1))
    else $error("Isochronous write full cycle missed");

  busy_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_BUSY && sel.unitMask == UM_04)
    |=> eventCount == $past(eventCount) + COUNT_W'($past(readOutstanding[2])))
    else $error("Read busy cycle count wrong");

  occ_all_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_NORMAL_OCC && sel.unitMask == UM_07)
    |=> eventCount == $past(eventCount) + COUNT_W'($past(normalReadOcc[0]))
        + COUNT_W'($past(normalReadOcc[1])) + COUNT_W'($past(normalReadOcc[2])))
    else $error("Summed normal occupancy wrong");

  isoc_occ_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_ISOC_OCC && sel.unitMask == UM_02)
    |=> eventCount == $past(eventCount) + COUNT_W'($past(isocReadOcc[1])))
    else $error("Isochronous channel 1 occupancy wrong");

  normal_reads_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sel.eventNum == EVT_NORMAL_READS && sel.unitMask == UM_01)
    |=> eventCount == $past(eventCount) + COUNT_W'($past(normalReadIssueCh0)))
    else $error("Channel 0 normal read count wrong");

endmodule

`default_nettype wire
